/* File: hw/sqe_pkg.sv */
package sqe_pkg;
	// ----------------------------------------------------------------
	// register offsets (byte addresses, one word each)
	// ----------------------------------------------------------------
	localparam logic [5:0] SQE_OFS_CTRL = 6'h00;
	localparam logic [5:0] SQE_OFS_UPD_FREQ = 6'h04;
	localparam logic [5:0] SQE_OFS_CNT_MOD = 6'h08;
	localparam logic [5:0] SQE_OFS_ENC_PPR = 6'h0C;
	localparam logic [5:0] SQE_OFS_DRV_RES = 6'h10;
	localparam logic [5:0] SQE_OFS_SCALE = 6'h14;
	localparam logic [5:0] SQE_OFS_DELTA_IN = 6'h18;
	localparam logic [5:0] SQE_OFS_PREV_CNT = 6'h1C;
	localparam logic [5:0] SQE_OFS_FRAC = 6'h20;
	localparam logic [5:0] SQE_OFS_SCALED = 6'h24;
	localparam logic [5:0] SQE_OFS_POS_OUT = 6'h28;
	localparam logic [5:0] SQE_OFS_ACCUM = 6'h2C;
	localparam logic [5:0] SQE_OFS_STATUS = 6'h30;
	// ----------------------------------------------------------------
	// control fields
	// ----------------------------------------------------------------
	localparam int SQE_CTRL_ENABLE_BIT = 0;
	localparam int SQE_CTRL_RESET_BIT = 1;
	localparam int SQE_CTRL_INDEX_BIT = 2;
	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] SQE_RST_UPD_FREQ = 32'h0000_0014;
	localparam logic [31:0] SQE_RST_CNT_MOD = 32'h2000_0000;
	localparam logic [31:0] SQE_RST_ENC_PPR = 32'h0000_2000;
	localparam logic [31:0] SQE_RST_DRV_RES = 32'h0001_0000;
	// scale 3.2768 in unsigned 16.16 fixed point
	localparam logic [31:0] SQE_RST_SCALE = 32'h0003_46DC;
	localparam int SQE_SCALE_FRAC_BITS = 16;
	// ----------------------------------------------------------------
	// timing: one quadrature step per update-frequency tick
	// ----------------------------------------------------------------
	localparam int SQE_CLK_MHZ = 10;
endpackage

/* File: hw/sqe_step_ram.sv */
`timescale 1ns/100ps
// small holding memory for pending step counts, registered read
module sqe_step_ram #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 2
) (
	// clock
	input wire logic core_clk_i,
	// write port
	input wire logic wr_en_i,
	input wire logic [$clog2(DEPTH)-1:0] wr_addr_i,
	input wire logic [WIDTH-1:0] wr_data_i,
	// read port
	input wire logic [$clog2(DEPTH)-1:0] rd_addr_i,
	output logic [WIDTH-1:0] rd_data_o
);
	if (DEPTH < 2 || WIDTH < 1) begin : g_bad_size
		$error("depth must be at least 2 and width at least 1");
	end

	logic [WIDTH-1:0] mem [DEPTH];

	// plain synchronous ram, no reset so it maps to memory cells
	always_ff @(posedge core_clk_i) begin
		if (wr_en_i) begin
			mem[wr_addr_i] <= wr_data_i;
		end
		rd_data_o <= mem[rd_addr_i];
	end
endmodule

/* File: hw/sqe_top.sv */
// Implementation choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/100ps
// How it works
// - firmware writes a 16-bit sampled position count as the only motion input.
// - pending counts are turned into an A/B quadrature pair.
// - writing 1 to the realtime clear bit zeroes the position accumulator.
// - the update frequency setting in whole MHz, default 20, paces the steps.
// - the position accumulator wraps at the modulus setting, default 536870912.
// - lines per revolution, default 8192, sets the emulated resolution.
// - drive counts per revolution, default 65536, is kept for readback only; scaling uses the scale setting.
// - raw delta is the current sampled count minus the previous one.
// - raw delta times the scale multiplier (default 3.2768) is the scaled delta.
// - the whole part of the scaled delta goes to the quadrature logic; the fraction is kept.
// - each phase leaves as a true and inverted differential pair.
module sqe_top
	import sqe_pkg::*;
#(
	parameter int CLK_MHZ = SQE_CLK_MHZ
) (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic arst_n_i,
	// avalon-mm slave
	input wire logic [5:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// encoder outputs
	output logic enc_a_p_o,
	output logic enc_a_n_o,
	output logic enc_b_p_o,
	output logic enc_b_n_o,
	output logic enc_idx_p_o,
	output logic enc_idx_n_o
);
	// ------------------------------------------------------------
	// elaboration checks
	// ------------------------------------------------------------
	if (CLK_MHZ < 1) begin : g_bad_clk
		$error("clock rate must be at least 1 MHz");
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic enable;
	logic index_type;
	logic [31:0] upd_freq;
	logic [31:0] cnt_mod;
	logic [31:0] enc_ppr;
	logic [31:0] drv_res;
	logic [31:0] scale;
	logic [15:0] curr_sampled_count;
	logic [15:0] prev_sampled_count;
	logic [15:0] frac;
	logic [31:0] scaled;
	logic signed [31:0] pos_out;
	logic [31:0] accum;
	logic signed [31:0] pending;
	logic [1:0] quad;
	logic clr_req;
	logic upd_pulse;
	logic acc_busy;
	logic acc_go;
	logic [31:0] tick_cnt;
	logic [31:0] rev_cnt;
	logic idx_q;
	logic [31:0] ram_q;

	wire logic bus_wr = avs_write_i && !avs_waitrequest_o;
	wire logic bus_rd = avs_read_i && !avs_waitrequest_o;

	function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// ------------------------------------------------------------
	// bus handshake: one wait cycle, then accept
	// ------------------------------------------------------------
	// the wait cycle gives the read mux a registered output
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			avs_waitrequest_o <= 1'b1;
		end else if ((avs_read_i || avs_write_i) && avs_waitrequest_o) begin
			avs_waitrequest_o <= 1'b0;
		end else begin
			avs_waitrequest_o <= 1'b1;
		end
	end

	// configuration registers
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			enable <= 1'b0;
			index_type <= 1'b0;
			upd_freq <= SQE_RST_UPD_FREQ;
			cnt_mod <= SQE_RST_CNT_MOD;
			enc_ppr <= SQE_RST_ENC_PPR;
			drv_res <= SQE_RST_DRV_RES;
			scale <= SQE_RST_SCALE;
		end else if (bus_wr) begin
			unique case (avs_address_i)
				SQE_OFS_CTRL: begin
					if (avs_byteenable_i[0]) begin
						enable <= avs_writedata_i[SQE_CTRL_ENABLE_BIT];
						index_type <= avs_writedata_i[SQE_CTRL_INDEX_BIT];
					end
				end
				SQE_OFS_UPD_FREQ: upd_freq <= merge_be(upd_freq, avs_writedata_i, avs_byteenable_i);
				SQE_OFS_CNT_MOD: cnt_mod <= merge_be(cnt_mod, avs_writedata_i, avs_byteenable_i);
				SQE_OFS_ENC_PPR: enc_ppr <= merge_be(enc_ppr, avs_writedata_i, avs_byteenable_i);
				SQE_OFS_DRV_RES: drv_res <= merge_be(drv_res, avs_writedata_i, avs_byteenable_i);
				SQE_OFS_SCALE: scale <= merge_be(scale, avs_writedata_i, avs_byteenable_i);
				default: ;
			endcase
		end
	end

	// realtime clear request, a self-clearing pulse
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			clr_req <= 1'b0;
		end else begin
			clr_req <= bus_wr && avs_address_i == SQE_OFS_CTRL && avs_byteenable_i[0]
				&& avs_writedata_i[SQE_CTRL_RESET_BIT];
		end
	end

	// delta sample port; needs both low byte lanes
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			curr_sampled_count <= 16'h0000;
			upd_pulse <= 1'b0;
		end else begin
			upd_pulse <= 1'b0;
			if (bus_wr && avs_address_i == SQE_OFS_DELTA_IN && &avs_byteenable_i[1:0]) begin
				curr_sampled_count <= avs_writedata_i[15:0];
				upd_pulse <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// delta scaling
	// ------------------------------------------------------------
	logic signed [16:0] raw_delta;
	logic signed [49:0] prod;
	logic signed [49:0] with_frac;
	assign raw_delta = $signed({curr_sampled_count[15], curr_sampled_count}) -
		$signed({prev_sampled_count[15], prev_sampled_count});
	// a 16-bit counter wraps, so fold the difference back into 16 bits
	logic signed [15:0] raw16;
	assign raw16 = raw_delta[15:0];
	// both operands widened first so the product keeps all of its bits
	assign prod = $signed({{34{raw16[15]}}, raw16}) * $signed({18'h0, scale});
	assign with_frac = prod + $signed({34'h0, frac});

	// update: store previous sample, whole part out, keep fraction
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			prev_sampled_count <= 16'h0000;
			frac <= 16'h0000;
			scaled <= 32'h0000_0000;
			pos_out <= 32'sh0;
		end else if (upd_pulse) begin
			prev_sampled_count <= curr_sampled_count;
			scaled <= with_frac[47:16];
			pos_out <= with_frac[47:16];
			frac <= with_frac[15:0];
		end
	end

	// ------------------------------------------------------------
	// step pacing: upd_freq MHz step rate derived from CLK_MHZ
	// ------------------------------------------------------------
	logic step_tick;
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			tick_cnt <= 32'h0;
			step_tick <= 1'b0;
		end else begin
			// rates above the core clock saturate at one step per cycle
			if (tick_cnt + upd_freq >= 32'(CLK_MHZ)) begin
				tick_cnt <= 32'h0;
				step_tick <= 1'b1;
			end else begin
				tick_cnt <= tick_cnt + upd_freq;
				step_tick <= 1'b0;
			end
		end
	end

	// each update's whole steps wait in a tiny ram slot, then add into pending
	sqe_step_ram #(.WIDTH(32), .DEPTH(2)) u_ram (
		.core_clk_i(core_clk_i),
		.wr_en_i(upd_pulse),
		.wr_addr_i(1'b0),
		.wr_data_i(with_frac[47:16]),
		.rd_addr_i(1'b0),
		.rd_data_o(ram_q)
	);

	logic stepping;
	assign stepping = enable && step_tick && pending != 0;

	// pending count, accumulator and quadrature state
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pending <= 32'sh0;
			acc_busy <= 1'b0;
			acc_go <= 1'b0;
		end else begin
			acc_busy <= upd_pulse;
			// the ram read lags its write by one edge, so add one cycle later
			acc_go <= acc_busy;
			if (acc_go) begin
				pending <= pending + $signed(ram_q) - (stepping ? (pending > 0 ? 32'sd1 : -32'sd1) : 32'sd0);
			end else if (stepping) begin
				pending <= pending > 0 ? pending - 32'sd1 : pending + 32'sd1;
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			accum <= 32'h0;
			quad <= 2'b00;
			rev_cnt <= 32'h0;
		end else if (clr_req) begin
			accum <= 32'h0;
			rev_cnt <= 32'h0;
		end else if (stepping) begin
			if (pending > 0) begin
				quad <= quad + 2'd1;
				accum <= (accum + 32'd1 >= cnt_mod) ? 32'h0 : accum + 32'd1;
				rev_cnt <= (rev_cnt + 32'd1 >= (enc_ppr << 2)) ? 32'h0 : rev_cnt + 32'd1;
			end else begin
				quad <= quad - 2'd1;
				accum <= (accum == 32'h0) ? cnt_mod - 32'd1 : accum - 32'd1;
				rev_cnt <= (rev_cnt == 32'h0) ? (enc_ppr << 2) - 32'd1 : rev_cnt - 32'd1;
			end
		end
	end

	// index: short marker at rev start, or high for half a revolution
	always_comb begin
		if (index_type) begin
			idx_q = rev_cnt < (enc_ppr << 1);
		end else begin
			idx_q = rev_cnt == 32'h0;
		end
	end

	// ------------------------------------------------------------
	// differential outputs, gray-coded quad: 00,10,11,01 = A leads
	// ------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			enc_a_p_o <= 1'b0;
			enc_a_n_o <= 1'b1;
			enc_b_p_o <= 1'b0;
			enc_b_n_o <= 1'b1;
			enc_idx_p_o <= 1'b0;
			enc_idx_n_o <= 1'b1;
		end else begin
			enc_a_p_o <= enable && (quad == 2'd1 || quad == 2'd2);
			enc_a_n_o <= !(enable && (quad == 2'd1 || quad == 2'd2));
			enc_b_p_o <= enable && quad[1];
			enc_b_n_o <= !(enable && quad[1]);
			enc_idx_p_o <= enable && idx_q;
			enc_idx_n_o <= !(enable && idx_q);
		end
	end

	// ------------------------------------------------------------
	// read mux
	// ------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			avs_readdata_o <= 32'h0;
		end else if ((avs_read_i) && avs_waitrequest_o) begin
			unique case (avs_address_i)
				SQE_OFS_CTRL: avs_readdata_o <= {29'h0, index_type, 1'b0, enable};
				SQE_OFS_UPD_FREQ: avs_readdata_o <= upd_freq;
				SQE_OFS_CNT_MOD: avs_readdata_o <= cnt_mod;
				SQE_OFS_ENC_PPR: avs_readdata_o <= enc_ppr;
				SQE_OFS_DRV_RES: avs_readdata_o <= drv_res;
				SQE_OFS_SCALE: avs_readdata_o <= scale;
				SQE_OFS_DELTA_IN: avs_readdata_o <= {16'h0, curr_sampled_count};
				SQE_OFS_PREV_CNT: avs_readdata_o <= {16'h0, prev_sampled_count};
				SQE_OFS_FRAC: avs_readdata_o <= {16'h0, frac};
				SQE_OFS_SCALED: avs_readdata_o <= scaled;
				SQE_OFS_POS_OUT: avs_readdata_o <= pos_out;
				SQE_OFS_ACCUM: avs_readdata_o <= accum;
				SQE_OFS_STATUS: avs_readdata_o <= pending;
				default: avs_readdata_o <= 32'h0; // unmapped reads zero
			endcase
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	sequence s_clear_write;
		bus_wr && avs_address_i == SQE_OFS_CTRL && avs_byteenable_i[0] && avs_writedata_i[SQE_CTRL_RESET_BIT];
	endsequence

	a_clear_zeroes_acc: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		s_clear_write |-> ##2 accum == 32'h0) else $error("accumulator not cleared");
	a_idle_when_off: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		!enable ##1 !enable |-> !enc_a_p_o && !enc_b_p_o) else $error("outputs moved while disabled");
	a_pair_complement: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		enc_a_p_o != enc_a_n_o && enc_b_p_o != enc_b_n_o) else $error("pair not complementary");
	a_one_step_only: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		1'b1 |=> quad == $past(quad) || quad == $past(quad) + 2'd1 || quad == $past(quad) - 2'd1)
		else $error("quadrature skipped a state");
	a_fwd_dir: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		stepping && pending > 0 && !acc_busy |=> quad == $past(quad) + 2'd1) else $error("wrong step direction");
	a_accum_wraps: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		accum < cnt_mod || $changed(cnt_mod)) else $error("accumulator past modulus");
	a_sample_taken: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		bus_wr && avs_address_i == SQE_OFS_DELTA_IN && &avs_byteenable_i[1:0]
		|=> curr_sampled_count == $past(avs_writedata_i[15:0]) ##1 prev_sampled_count == $past(curr_sampled_count))
		else $error("sample not latched");
	a_frac_kept: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		upd_pulse |=> frac == $past(with_frac[15:0]) && pos_out == $past(with_frac[47:16]))
		else $error("fraction not carried");
endmodule

/* File: verif/sqe_enc_counter.sv */
`timescale 1ns/100ps
// far-side counter: x4 decode of the emulated encoder lines
module sqe_enc_counter (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic arst_n_i,
	// encoder lines
	input wire logic a_p_i,
	input wire logic a_n_i,
	input wire logic b_p_i,
	input wire logic b_n_i,
	input wire logic idx_p_i,
	input wire logic idx_n_i,
	// results
	output logic signed [31:0] count_o,
	output logic [15:0] fault_o
);
	logic [1:0] prev;
	logic [3:0] tr;
	logic skip;
	logic pair_bad;
	// ----------------------------------------
	// decode
	// ----------------------------------------
	assign tr = {prev, a_p_i, b_p_i};
	// a double change cannot be counted by a real receiver
	assign skip = (prev[1] != a_p_i) && (prev[0] != b_p_i);
	assign pair_bad = (a_n_i !== ~a_p_i) || (b_n_i !== ~b_p_i) || (idx_n_i !== ~idx_p_i);
	// a leading b counts up, b leading a counts down
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			prev <= 2'h0;
			count_o <= '0;
			fault_o <= '0;
		end else begin
			prev <= {a_p_i, b_p_i};
			fault_o <= fault_o + 16'(skip) + 16'(pair_bad);
			if (tr inside {4'b0010, 4'b1011, 4'b1101, 4'b0100}) begin
				count_o <= count_o + 1;
			end else if (tr inside {4'b0001, 4'b0111, 4'b1110, 4'b1000}) begin
				count_o <= count_o - 1;
			end
		end
	end
endmodule

/* File: verif/simulated_quadrature_encoder_out_bench.sv */
`timescale 1ns/100ps
module simulated_quadrature_encoder_out_bench;
	import sqe_pkg::*;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic [5:0] addr = 6'h00;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] ben = 4'hF;
	logic [31:0] rdata;
	logic wreq;
	logic a_p, a_n, b_p, b_n, i_p, i_n;
	logic signed [31:0] cnt;
	logic [15:0] faults;
	int errors = 0;
	int total_checks = 0;
	logic [31:0] q;
	// ----------------------------------------
	// clock, design and far side
	// ----------------------------------------
	always #50 clk = ~clk;
	sqe_top #(.CLK_MHZ(10)) i_dut (.core_clk_i(clk), .arst_n_i(arst_n), .avs_address_i(addr),
		.avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(ben),
		.avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .enc_a_p_o(a_p), .enc_a_n_o(a_n),
		.enc_b_p_o(b_p), .enc_b_n_o(b_n), .enc_idx_p_o(i_p), .enc_idx_n_o(i_n));
	sqe_enc_counter i_far (.core_clk_i(clk), .arst_n_i(arst_n), .a_p_i(a_p), .a_n_i(a_n), .b_p_i(b_p),
		.b_n_i(b_n), .idx_p_i(i_p), .idx_n_i(i_n), .count_o(cnt), .fault_o(faults));
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// one edge passes first so a release is never overwritten in its own step
	task automatic bus(input logic we, input logic [5:0] a, input logic [31:0] d, input logic [3:0] be);
		int n;
		n = 0;
		@(posedge clk);
		addr <= a;
		wr <= we;
		rd <= !we;
		wdata <= d;
		ben <= be;
		do begin
			@(posedge clk);
			n++;
		end while (wreq !== 1'b0 && n < 100);
		if (n >= 100) chk("waitrequest", 32'h0, 32'h1);
		q = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask
	task automatic wreg(input logic [5:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 4'hF);
	endtask
	task automatic rchk(input string what, input logic [5:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0, 4'hF);
		chk(what, exp, q);
	endtask
	// the pace of steps is the design's own, so wait on the count
	task automatic wait_cnt(input logic [31:0] exp);
		for (int i = 0; i < 300 && cnt !== exp; i++) @(posedge clk);
		chk("far count", exp, cnt);
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// ----------------------------------------
	// watchdog
	// ----------------------------------------
	initial begin
		#2000000;
		errors++;
		conclude();
	end
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		rchk("ctrl", SQE_OFS_CTRL, 32'h0);
		rchk("upd freq", SQE_OFS_UPD_FREQ, SQE_RST_UPD_FREQ);
		rchk("modulus", SQE_OFS_CNT_MOD, 32'h2000_0000);
		rchk("ppr", SQE_OFS_ENC_PPR, 32'h0000_2000);
		rchk("drive res", SQE_OFS_DRV_RES, 32'h0001_0000);
		rchk("scale", SQE_OFS_SCALE, SQE_RST_SCALE);
		rchk("unmapped", 6'h3C, 32'h0);
		$display("test reset values done");
		wreg(SQE_OFS_SCALE, 32'h0001_0000);
		wreg(SQE_OFS_DELTA_IN, 32'h0000_FFFD);
		repeat (4) @(posedge clk);
		rchk("pending", SQE_OFS_STATUS, 32'hFFFF_FFFD);
		chk("idle a b", 32'h0, {30'h0, a_p, b_p});
		wreg(SQE_OFS_CTRL, 32'h1);
		wait_cnt(32'hFFFF_FFFD);
		wreg(SQE_OFS_DELTA_IN, 32'h0);
		wait_cnt(32'h0);
		$display("test direction done");
		bus(1'b1, SQE_OFS_DELTA_IN, 32'h0000_0005, 4'hC);
		repeat (20) @(posedge clk);
		chk("far count", 32'h0, cnt);
		$display("test partial write done");
		wreg(SQE_OFS_SCALE, SQE_RST_SCALE);
		wreg(SQE_OFS_DELTA_IN, 32'd10);
		wait_cnt(32'd32);
		rchk("scaled whole", SQE_OFS_SCALED, 32'h20);
		rchk("fraction", SQE_OFS_FRAC, 32'hC498);
		rchk("delta out", SQE_OFS_POS_OUT, 32'h20);
		rchk("prev sample", SQE_OFS_PREV_CNT, 32'd10);
		wreg(SQE_OFS_DELTA_IN, 32'd20);
		wait_cnt(32'd65);
		rchk("accum", SQE_OFS_ACCUM, 32'd65);
		$display("test scaling done");
		// clear first: a modulus below the live count would leave it out of range
		wreg(SQE_OFS_CTRL, 32'h3);
		wreg(SQE_OFS_CNT_MOD, 32'h8);
		wreg(SQE_OFS_ENC_PPR, 32'h2);
		wreg(SQE_OFS_SCALE, 32'h0001_0000);
		repeat (3) @(posedge clk);
		rchk("accum cleared", SQE_OFS_ACCUM, 32'h0);
		rchk("ctrl", SQE_OFS_CTRL, 32'h1);
		chk("index at zero", 32'h1, {31'h0, i_p});
		wreg(SQE_OFS_DELTA_IN, 32'd30);
		wait_cnt(32'd75);
		rchk("accum wrap", SQE_OFS_ACCUM, 32'h2);
		wreg(SQE_OFS_CTRL, 32'h5);
		repeat (3) @(posedge clk);
		chk("half index", 32'h1, {31'h0, i_p});
		wreg(SQE_OFS_CTRL, 32'h1);
		repeat (3) @(posedge clk);
		chk("plain index", 32'h0, {31'h0, i_p});
		chk("line faults", 32'h0, {16'h0, faults});
		$display("test clear wrap index done");
		conclude();
	end
endmodule
